// *** design/txmon_defines.svh ***
`ifndef TXMON_DEFINES_SVH
`define TXMON_DEFINES_SVH

`define TXMON_CTRL4_ADDR    8'hA8
`define TXMON_TXMON_ADDR    8'hA9
`define TXMON_CTRL5_ADDR    8'hAA
`define TXMON_RXMON_ADDR    8'hAB
`define TXMON_CTRL4_RESET   8'h00
`define TXMON_CTRL5_RESET   8'h00
`define TXMON_MON_RESET     8'h00
`define TXMON_LOOP_BIT      7
`define TXMON_SEL_MSB       4
`define TXMON_SEL_LSB       0
`define TXMON_SLOT_BITS     8
`define TXMON_FRAME_SLOTS   32

`endif

// *** design/txmon_pkg.sv ***
package txmon_pkg;
	typedef enum logic [2:0] {
		TXMON_SEL_NONE  = 3'b000,
		TXMON_SEL_CTRL4 = 3'b001,
		TXMON_SEL_TXMON = 3'b010,
		TXMON_SEL_CTRL5 = 3'b011,
		TXMON_SEL_RXMON = 3'b100
	} txmon_regsel_type;

	typedef logic [7:0] txmon_byte_type;
	typedef logic [4:0] txmon_slot_type;
endpackage

// *** design/txmon_slot_capture.sv ***
`include "txmon_defines.svh"

module txmon_slot_capture #(
	parameter int SLOT_BITS   = `TXMON_SLOT_BITS,
	parameter int FRAME_SLOTS = `TXMON_FRAME_SLOTS
) (
	input  wire logic                   clock,
	input  wire logic                   rst_b,
	input  wire logic                   serialBit,
	input  wire logic                   bitStrobe,
	input  wire logic                   frameSync,
	input  wire txmon_pkg::txmon_slot_type slotSelect,
	output logic [SLOT_BITS-1:0]        monByte
);
	import txmon_pkg::*;

	localparam int BW = $clog2(SLOT_BITS);
	localparam int SW = $clog2(FRAME_SLOTS);

	logic [BW+SW-1:0]     bitCount_reg;
	logic [BW+SW-1:0]     bitCount_next;
	logic [BW+SW-1:0]     bitPos;
	logic [SLOT_BITS-1:0] shift_reg;
	logic [SLOT_BITS-1:0] shiftIn;
	logic [SLOT_BITS-1:0] monByte_reg;
	logic                 slotDone;

	// frame sync marks the strobe that carries the first bit of slot zero
	assign bitPos        = frameSync ? '0 : bitCount_reg;
	assign bitCount_next = (BW+SW)'(bitPos + 1'b1);
	// first sent bit shifts in first and lands in the msb
	assign shiftIn       = {shift_reg[SLOT_BITS-2:0], serialBit}; // RULE_05
	// selector code equals channel number minus one, i.e. the timeslot index
	assign slotDone      = bitStrobe && (&bitPos[BW-1:0])
		&& (bitPos[BW+SW-1:BW] == slotSelect[SW-1:0]); // RULE_06

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			bitCount_reg <= '0;
			shift_reg    <= '0;
			monByte_reg  <= `TXMON_MON_RESET;
		end else if (bitStrobe) begin
			bitCount_reg <= bitCount_next;
			shift_reg    <= shiftIn;
			// refresh only when the chosen slot completes; a read sees a whole byte
			if (slotDone) begin
				monByte_reg <= shiftIn; // RULE_04 RULE_08
			end
		end
	end

	assign monByte = monByte_reg;
endmodule

// *** design/txmon_regs.sv ***
`include "txmon_defines.svh"

// Operation
// (RULE_01) control four bit 7 set enables remote loopback, clear disables it.
// (RULE_02) host writes zero to control four bits 6 and 5; unassigned.
// (RULE_03) control four bits 4..0 are the transmit slot selector, bit 4 msb.
// (RULE_04) transmit monitor register shows the byte of the selected transmit slot.
// (RULE_05) monitor bit 7 holds first sent bit, bit 0 the last sent.
// (RULE_06) selector code is channel number minus one: channels 1..32 as 0..31.
// (RULE_07) control five bits 4..0 select the receive slot shown in receive monitor.
// (RULE_08) monitor refreshes once per frame as the selected slot completes.
module txmon_regs #(
	parameter int ADDR_BITS   = 8,
	parameter int FRAME_SLOTS = `TXMON_FRAME_SLOTS
) (
	input  wire logic                      clock,
	input  wire logic                      rst_b,
	input  wire logic [ADDR_BITS-1:0]      address,
	input  wire logic                      writeStrobe,
	input  wire logic                      readStrobe,
	input  wire txmon_pkg::txmon_byte_type writeData,
	output txmon_pkg::txmon_byte_type      readData,
	input  wire logic                      txSerialBit,
	input  wire logic                      txBitStrobe,
	input  wire logic                      txFrameSync,
	input  wire logic                      rxSerialBit,
	input  wire logic                      rxBitStrobe,
	input  wire logic                      rxFrameSync,
	output logic                           remoteLoopEnable
);
	import txmon_pkg::*;

	// direction index of the two monitor channels
	localparam int NDIR   = 2;
	localparam int DIR_TX = 0;
	localparam int DIR_RX = 1;

	// decoded addresses
	localparam logic [ADDR_BITS-1:0] CTRL4_ADDR = ADDR_BITS'(`TXMON_CTRL4_ADDR);
	localparam logic [ADDR_BITS-1:0] TXMON_ADDR = ADDR_BITS'(`TXMON_TXMON_ADDR);
	localparam logic [ADDR_BITS-1:0] CTRL5_ADDR = ADDR_BITS'(`TXMON_CTRL5_ADDR);
	localparam logic [ADDR_BITS-1:0] RXMON_ADDR = ADDR_BITS'(`TXMON_RXMON_ADDR);

	// reset images of the registers
	localparam txmon_byte_type CTRL4_RESET = `TXMON_CTRL4_RESET;
	localparam txmon_byte_type CTRL5_RESET = `TXMON_CTRL5_RESET;
	localparam txmon_byte_type READ_RESET  = `TXMON_MON_RESET;
	localparam txmon_byte_type READ_NONE   = 8'h00;

	// control four state
	logic             loopEnable_reg;
	logic             loopEnable_next;
	txmon_slot_type   txSelect_reg;
	txmon_slot_type   txSelect_next;

	// control five state
	txmon_slot_type   rxSelect_reg;
	txmon_slot_type   rxSelect_next;

	// read port state
	txmon_byte_type   readData_reg;
	txmon_byte_type   readData_next;

	// address decode
	logic             hitCtrl4;
	logic             hitTxMon;
	logic             hitCtrl5;
	logic             hitRxMon;
	txmon_regsel_type regSelect;
	logic             writeCtrl4;
	logic             writeCtrl5;

	// read views
	txmon_byte_type   ctrl4View;
	txmon_byte_type   ctrl5View;
	txmon_byte_type   readMux;

	// per-direction serial side, index 0 transmit, index 1 receive
	logic           [NDIR-1:0] dirSerialBit;
	logic           [NDIR-1:0] dirBitStrobe;
	logic           [NDIR-1:0] dirFrameSync;
	txmon_slot_type [NDIR-1:0] dirSelect;
	txmon_byte_type [NDIR-1:0] dirMonByte;

	// one hit per decoded address; any other address reads as zero
	assign hitCtrl4 = (address == CTRL4_ADDR);
	assign hitTxMon = (address == TXMON_ADDR);
	assign hitCtrl5 = (address == CTRL5_ADDR);
	assign hitRxMon = (address == RXMON_ADDR);

	assign regSelect = hitCtrl4 ? TXMON_SEL_CTRL4
		: hitTxMon ? TXMON_SEL_TXMON
		: hitCtrl5 ? TXMON_SEL_CTRL5
		: hitRxMon ? TXMON_SEL_RXMON
		: TXMON_SEL_NONE;

	// the monitor bytes are read only; a write there is dropped
	assign writeCtrl4 = writeStrobe && (regSelect == TXMON_SEL_CTRL4);
	assign writeCtrl5 = writeStrobe && (regSelect == TXMON_SEL_CTRL5);

	// loopback enable lives in the top bit of control four
	assign loopEnable_next = writeCtrl4
		? writeData[`TXMON_LOOP_BIT]
		: loopEnable_reg; // RULE_01

	// low five bits pick the transmit slot, bit 4 most significant
	assign txSelect_next = writeCtrl4
		? writeData[`TXMON_SEL_MSB:`TXMON_SEL_LSB]
		: txSelect_reg; // RULE_03

	// same layout in control five picks the receive slot
	assign rxSelect_next = writeCtrl5
		? writeData[`TXMON_SEL_MSB:`TXMON_SEL_LSB]
		: rxSelect_reg; // RULE_07

	// bits 6 and 5 are not stored, so a stray write of ones cannot stick
	assign ctrl4View = {loopEnable_reg, 2'b00, txSelect_reg};
	// only the receive selector of control five is kept here
	assign ctrl5View = {3'b000, rxSelect_reg};

	// a read samples the addressed byte; it stands until the next read
	assign readMux = (regSelect == TXMON_SEL_CTRL4) ? ctrl4View
		: (regSelect == TXMON_SEL_TXMON) ? dirMonByte[DIR_TX] // RULE_04
		: (regSelect == TXMON_SEL_CTRL5) ? ctrl5View
		: (regSelect == TXMON_SEL_RXMON) ? dirMonByte[DIR_RX] // RULE_07
		: READ_NONE;

	assign readData_next = readStrobe ? readMux : readData_reg;

	// gather both directions so one loop serves them
	assign dirSerialBit[DIR_TX] = txSerialBit;
	assign dirSerialBit[DIR_RX] = rxSerialBit;
	assign dirBitStrobe[DIR_TX] = txBitStrobe;
	assign dirBitStrobe[DIR_RX] = rxBitStrobe;
	assign dirFrameSync[DIR_TX] = txFrameSync;
	assign dirFrameSync[DIR_RX] = rxFrameSync;
	assign dirSelect[DIR_TX]    = txSelect_reg;
	assign dirSelect[DIR_RX]    = rxSelect_reg;

	// each direction watches its own slot with its own timing
	genvar d;
	generate
		for (d = 0; d < NDIR; d++) begin : g_dir
			txmon_slot_capture #(
				.SLOT_BITS   (`TXMON_SLOT_BITS),
				.FRAME_SLOTS (FRAME_SLOTS)
			) u_txmon_slot_capture (
				.clock      (clock),
				.rst_b      (rst_b),
				.serialBit  (dirSerialBit[d]),
				.bitStrobe  (dirBitStrobe[d]),
				.frameSync  (dirFrameSync[d]),
				.slotSelect (dirSelect[d]),
				.monByte    (dirMonByte[d])
			);
		end
	endgenerate

	// loopback enable; the loop path itself sits outside this block
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			loopEnable_reg <= CTRL4_RESET[`TXMON_LOOP_BIT];
		end else begin
			loopEnable_reg <= loopEnable_next; // RULE_01
		end
	end

	// transmit selector; a change takes effect at the next slot pass
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			txSelect_reg <= CTRL4_RESET[`TXMON_SEL_MSB:`TXMON_SEL_LSB];
		end else begin
			txSelect_reg <= txSelect_next; // RULE_03
		end
	end

	// receive selector
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rxSelect_reg <= CTRL5_RESET[`TXMON_SEL_MSB:`TXMON_SEL_LSB];
		end else begin
			rxSelect_reg <= rxSelect_next; // RULE_07
		end
	end

	// registered read data costs one cycle but keeps the output glitch free
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			readData_reg <= READ_RESET;
		end else begin
			readData_reg <= readData_next;
		end
	end

	assign readData         = readData_reg;
	assign remoteLoopEnable = loopEnable_reg;
endmodule

// *** tb/txmon_chk.sv ***
`include "txmon_defines.svh"

module txmon_chk (
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic [7:0] address,
	input wire logic       writeStrobe,
	input wire logic       readStrobe,
	input wire logic [7:0] writeData,
	input wire logic [7:0] readData,
	input wire logic       txSerialBit,
	input wire logic       txBitStrobe,
	input wire logic       txFrameSync,
	input wire logic       rxSerialBit,
	input wire logic       rxBitStrobe,
	input wire logic       rxFrameSync,
	input wire logic       remoteLoopEnable
);
	timeunit 1ns;
	timeprecision 1ps;
	logic wrCtrl4;
	logic wrCtrl5;
	logic rdCtrl4;
	logic rdCtrl5;
	logic rdTxMon;
	assign wrCtrl4 = writeStrobe && (address == `TXMON_CTRL4_ADDR);
	assign wrCtrl5 = writeStrobe && (address == `TXMON_CTRL5_ADDR);
	assign rdCtrl4 = readStrobe && (address == `TXMON_CTRL4_ADDR);
	assign rdCtrl5 = readStrobe && (address == `TXMON_CTRL5_ADDR);
	assign rdTxMon = readStrobe && (address == `TXMON_TXMON_ADDR);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	loop_follows_write_a: assert property (
		wrCtrl4 |=> remoteLoopEnable == $past(writeData[`TXMON_LOOP_BIT]))
		else $error("loop enable did not follow write");
	loop_holds_a: assert property (
		!wrCtrl4 |=> $stable(remoteLoopEnable))
		else $error("loop enable moved without write");
	loop_readback_a: assert property (
		rdCtrl4 |=> readData[`TXMON_LOOP_BIT] == $past(remoteLoopEnable))
		else $error("loop bit read back wrong");
	tx_select_readback_a: assert property (
		wrCtrl4 ##1 rdCtrl4 |=> readData[4:0] == $past(writeData[4:0], 2))
		else $error("transmit selector read back wrong");
	rx_select_readback_a: assert property (
		wrCtrl5 ##1 rdCtrl5 |=> readData[4:0] == $past(writeData[4:0], 2))
		else $error("receive selector read back wrong");
	read_holds_a: assert property (
		!readStrobe |=> $stable(readData))
		else $error("read data moved without read");
	monitor_holds_a: assert property (
		rdTxMon && !txBitStrobe ##1 rdTxMon |=> $stable(readData))
		else $error("monitor byte moved without strobe");
endmodule
bind txmon_regs txmon_chk u_txmon_chk (.clock(clock), .rst_b(rst_b), .address(address),
	.writeStrobe(writeStrobe), .readStrobe(readStrobe), .writeData(writeData),
	.readData(readData), .txSerialBit(txSerialBit), .txBitStrobe(txBitStrobe),
	.txFrameSync(txFrameSync), .rxSerialBit(rxSerialBit), .rxBitStrobe(rxBitStrobe),
	.rxFrameSync(rxFrameSync), .remoteLoopEnable(remoteLoopEnable));

// *** tb/testbench.sv ***
`include "txmon_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock = 1'b0;
	logic       rst_b = 1'b0;
	logic [7:0] address = 8'h00;
	logic       writeStrobe = 1'b0;
	logic       readStrobe = 1'b0;
	logic [7:0] writeData = 8'h00;
	logic [7:0] readData;
	logic       txSerialBit = 1'b0;
	logic       txBitStrobe = 1'b0;
	logic       txFrameSync = 1'b0;
	logic       rxSerialBit = 1'b0;
	logic       rxBitStrobe = 1'b0;
	logic       rxFrameSync = 1'b0;
	logic       remoteLoopEnable;
	int         n_errors = 0;
	int         total_checks = 0;
	always #2.5 clock = ~clock;
	txmon_regs u_txmon_regs (.clock(clock), .rst_b(rst_b), .address(address),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .writeData(writeData),
		.readData(readData), .txSerialBit(txSerialBit), .txBitStrobe(txBitStrobe),
		.txFrameSync(txFrameSync), .rxSerialBit(rxSerialBit), .rxBitStrobe(rxBitStrobe),
		.rxFrameSync(rxFrameSync), .remoteLoopEnable(remoteLoopEnable));
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// bus tasks start and end just after a rising edge; strobes are taken at the next edge
	task bus_write(input logic [7:0] addr, input logic [7:0] data);
		address     = addr;
		writeData   = data;
		writeStrobe = 1'b1;
		readStrobe  = 1'b0;
		@(posedge clock) #1;
	endtask
	task bus_read(input logic [7:0] addr, output logic [7:0] data);
		address     = addr;
		readStrobe  = 1'b1;
		writeStrobe = 1'b0;
		@(posedge clock) #1;
		data = readData;
	endtask
	task bus_idle;
		writeStrobe = 1'b0;
		readStrobe  = 1'b0;
		@(posedge clock) #1;
	endtask
	task test_registers;
		logic [7:0] got;
		bus_write(`TXMON_CTRL4_ADDR, 8'h85);
		bus_read(`TXMON_CTRL4_ADDR, got);
		check("control four", got, 8'h85);
		check("loop enable on", {7'h00, remoteLoopEnable}, 8'h01);
		bus_write(`TXMON_CTRL5_ADDR, 8'h0E);
		bus_read(`TXMON_CTRL5_ADDR, got);
		check("control five", got, 8'h0E);
		bus_write(`TXMON_CTRL4_ADDR, 8'h05);
		bus_read(`TXMON_CTRL4_ADDR, got);
		check("control four", got, 8'h05);
		check("loop enable off", {7'h00, remoteLoopEnable}, 8'h00);
		bus_idle();
		$display("register test done");
	endtask
	task test_reset;
		logic [7:0] got;
		bus_write(`TXMON_CTRL4_ADDR, 8'h9F);
		bus_idle();
		rst_b = 1'b0;
		repeat (2) @(posedge clock);
		#1 rst_b = 1'b1;
		bus_read(`TXMON_CTRL4_ADDR, got);
		check("control four after reset", got, `TXMON_CTRL4_RESET);
		check("loop enable after reset", {7'h00, remoteLoopEnable}, 8'h00);
		bus_read(`TXMON_TXMON_ADDR, got);
		check("tx monitor after reset", got, `TXMON_MON_RESET);
		bus_idle();
		$display("reset test done");
	endtask
	task finish_test;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// slot s carries seed+s on transmit and seed+s+40h on receive, msb sent first
	task run_frame(input int txChan, input int rxChan, input logic [7:0] seed);
		logic [4:0] txSel;
		logic [4:0] rxSel;
		logic [7:0] txByte;
		logic [7:0] rxByte;
		logic [7:0] got;
		txSel = 5'(txChan - 1);
		rxSel = 5'(rxChan - 1);
		bus_write(`TXMON_CTRL4_ADDR, {3'b000, txSel});
		bus_write(`TXMON_CTRL5_ADDR, {3'b000, rxSel});
		bus_idle();
		for (int i = 0; i < 256; i++) begin
			txByte      = seed + 8'(i / 8);
			rxByte      = txByte + 8'h40;
			txFrameSync = (i == 0);
			rxFrameSync = (i == 0);
			txBitStrobe = 1'b1;
			rxBitStrobe = 1'b1;
			txSerialBit = txByte[7 - i % 8];
			rxSerialBit = rxByte[7 - i % 8];
			@(posedge clock) #1;
		end
		txBitStrobe = 1'b0;
		rxBitStrobe = 1'b0;
		txFrameSync = 1'b0;
		rxFrameSync = 1'b0;
		bus_read(`TXMON_TXMON_ADDR, got);
		check("tx monitor", got, seed + 8'(txSel));
		bus_read(`TXMON_TXMON_ADDR, got);
		check("tx monitor again", got, seed + 8'(txSel));
		bus_read(`TXMON_RXMON_ADDR, got);
		check("rx monitor", got, seed + 8'h40 + 8'(rxSel));
		bus_idle();
		$display("frame tx %0d rx %0d done", txChan, rxChan);
	endtask
	initial begin
		repeat (4) @(posedge clock);
		#1 rst_b = 1'b1;
		test_registers();
		run_frame(6, 15, 8'h3C);
		run_frame(32, 1, 8'h80);
		run_frame(1, 32, 8'hC3);
		test_reset();
		finish_test();
	end
	// three frames of 256 bits need about 4 us
	initial begin
		#20000;
		n_errors++;
		finish_test();
	end
endmodule
